// [cpb_defs.svh]
// Register map, field positions and constants of the complementary PWM block
// What this block does
// - Transfer D0->B0, C1->A1, D1->B1 on event
// - Period cannot change during operation
// - Counter 0 turns down: m-1, m, m+1, m, m-1
// - m to m+1 sets match flag, transfers if 11B
// - Around the peak, no flag change, no transfer
// - Counter 1 turns up: 1, 0, FFFFH, 0, 1
// - 0 to FFFFH sets underflow, transfers if 10B
// - Around the trough, no transfer, overflow unchanged
// - Buffer >= period transfers at underflow, 100%/0%
// - Then first mid value transfers at underflow
// - Untouched buffer reset value FFFFH never transfers, never forces 0%
// - Buffer 0000H transfers at period match, 0%/100%
// - Then first mid value transfers at period match
// - Leaving fixed level via mid value, then normal timing
// - No direct jump between the two fixed states
`ifndef CPB_DEFS_SVH
`define CPB_DEFS_SVH
`define CPB_OFS_CTRL 8'h00
`define CPB_OFS_STAT 8'h04
`define CPB_OFS_PERIOD 8'h08
`define CPB_OFS_GEN0 8'h0c
`define CPB_OFS_GEN1 8'h10
`define CPB_OFS_GEN2 8'h14
`define CPB_OFS_BUF0 8'h18
`define CPB_OFS_BUF1 8'h1c
`define CPB_OFS_BUF2 8'h20
`define CPB_OFS_BSEL 8'h24
`define CPB_OFS_CNT0 8'h28
`define CPB_OFS_CNT1 8'h2c
`define CPB_CTRL_RUN0 0
`define CPB_CTRL_RUN1 1
`define CPB_CTRL_MODE 3:2
`define CPB_CTRL_NORMAL_PHASE_LEVEL_SEL 4
`define CPB_CTRL_COUNTER_PHASE_LEVEL_SEL 5
`define CPB_STAT_W 3
`define CPB_MODE_TIMER 2'b00
`define CPB_MODE_UDF 2'b10
`define CPB_MODE_CMA 2'b11
`define CPB_CNT_MAX 16'hffff
`define CPB_CNT_ZERO 16'h0000
`define CPB_CNT_ONE 16'h0001
`define CPB_REG_RST 16'hffff
`define CPB_RESP_OK 2'b00
`define CPB_RESP_ERR 2'b10
`endif

// [cpb_phase.sv]
// Normal and counter phase output pair for one duty channel
`include "cpb_defs.svh"
module cpb_phase (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic active,
	input wire logic [15:0] cnt0,
	input wire logic [15:0] cnt1,
	input wire logic [15:0] gen,
	input wire logic [15:0] period,
	input wire logic ols_n,
	input wire logic ols_c,
	output logic out_n,
	output logic out_c
);
	logic act_n;
	logic act_c;

	always_comb begin
		if (gen >= period) begin
			act_n = 1'b1;
			act_c = 1'b0;
		end else if (gen == `CPB_CNT_ZERO) begin
			act_n = 1'b0;
			act_c = 1'b1;
		end else begin
			act_n = cnt0 <= gen;
			act_c = cnt1 > gen;
		end
	end

	// Stopped outputs rest at the inactive level chosen by the level selects
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_n <= 1'b1;
			out_c <= 1'b1;
		end else begin
			out_n <= (active && act_n) ? ols_n : ~ols_n;
			out_c <= (active && act_c) ? ols_c : ~ols_c;
		end
	end
endmodule // cpb_phase

// [cpb_pkg.sv]
// Types shared by the complementary PWM block
package cpb_pkg;
	typedef enum logic [1:0] {
		cpb_fix_none = 2'b00,
		cpb_fix_full = 2'b01,
		cpb_fix_zero = 2'b10
	} cpb_fix_t;
endpackage

// [cpb_top.sv]
// Complementary PWM timer with buffered duty transfer and AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`include "cpb_defs.svh"
module cpb_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [2:0] pwm_normal,
	output logic [2:0] pwm_counter
);
	logic counter0_run_bit;
	logic counter1_run_bit;
	logic combination_mode_hi;
	logic combination_mode_lo;
	logic normal_phase_level_sel;
	logic counter_phase_level_sel;
	logic [15:0] period_compare_a_ch0;
	logic [15:0] buf_q [3];
	logic [15:0] gen [3];
	logic [2:0] bsel;
	logic [15:0] counter_ch0;
	logic [15:0] counter_ch1;
	logic dir_up;
	logic compare_match_a_flag;
	logic underflow_flag;
	logic overflow_flag;

	logic aw_held;
	logic w_held;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;
	logic wr_hit;
	logic [15:0] wr16_ctrl;
	logic [1:0] mode;
	logic comp;
	logic running;
	logic cm_ev;
	logic udf_ev;
	logic ovf_ev;
	logic [2:0] stat_clr;
	logic [31:0] next_rdata;
	logic rd_hit;
	logic [2:0] buf_wr;
	logic [2:0] gen_wr;
	logic [15:0] wmerge [3];
	logic [15:0] cnt0_merge;
	logic [15:0] cnt1_merge;
	logic [15:0] period_merge;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction

	assign mode = {combination_mode_hi, combination_mode_lo};
	assign comp = mode[1];
	assign running = comp ? (counter0_run_bit && counter1_run_bit) : counter0_run_bit;

	// Write channel: address and data taken in either order, answer after both
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		// Full byte address, so the decode matches the register strobes below
		unique case (awaddr_q)
			`CPB_OFS_CTRL, `CPB_OFS_STAT, `CPB_OFS_PERIOD,
			`CPB_OFS_GEN0, `CPB_OFS_GEN1, `CPB_OFS_GEN2,
			`CPB_OFS_BUF0, `CPB_OFS_BUF1, `CPB_OFS_BUF2,
			`CPB_OFS_BSEL, `CPB_OFS_CNT0, `CPB_OFS_CNT1: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CPB_RESP_OK;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `CPB_RESP_OK : `CPB_RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign wr16_ctrl = merge16({10'h000, counter_phase_level_sel, normal_phase_level_sel,
		mode, counter1_run_bit, counter0_run_bit}, wdata_q, wstrb_q);

	// Mode and level selects only change with both counters stopped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter0_run_bit <= 1'b0;
			counter1_run_bit <= 1'b0;
			combination_mode_hi <= 1'b0;
			combination_mode_lo <= 1'b0;
			normal_phase_level_sel <= 1'b0;
			counter_phase_level_sel <= 1'b0;
		end else if (wr_fire && awaddr_q == `CPB_OFS_CTRL) begin
			counter0_run_bit <= wr16_ctrl[`CPB_CTRL_RUN0];
			counter1_run_bit <= wr16_ctrl[`CPB_CTRL_RUN1];
			if (!counter0_run_bit && !counter1_run_bit) begin
				{combination_mode_hi, combination_mode_lo} <= wr16_ctrl[`CPB_CTRL_MODE];
				normal_phase_level_sel <= wr16_ctrl[`CPB_CTRL_NORMAL_PHASE_LEVEL_SEL];
				counter_phase_level_sel <= wr16_ctrl[`CPB_CTRL_COUNTER_PHASE_LEVEL_SEL];
			end
		end
	end

	assign period_merge = merge16(period_compare_a_ch0, wdata_q, wstrb_q);

	// Period is frozen while counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_compare_a_ch0 <= `CPB_REG_RST;
		end else if (wr_fire && awaddr_q == `CPB_OFS_PERIOD && !running) begin
			period_compare_a_ch0 <= period_merge;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_chan
			assign wmerge[gi] = merge16(buf_q[gi], wdata_q, wstrb_q);
			assign buf_wr[gi] = wr_fire && awaddr_q == 8'(`CPB_OFS_BUF0 + 4 * gi);
			// Direct compare writes are dropped while counting
			assign gen_wr[gi] = wr_fire && !running &&
				awaddr_q == 8'(`CPB_OFS_GEN0 + 4 * gi);

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					buf_q[gi] <= `CPB_REG_RST;
				end else if (buf_wr[gi]) begin
					buf_q[gi] <= wmerge[gi];
				end
			end

			cpb_xfer u_xfer (
				.aclk(aclk),
				.aresetn(aresetn),
				.buf_val(buf_q[gi]),
				.buf_wr(buf_wr[gi]),
				.gen_wr(gen_wr[gi]),
				.gen_wdata(merge16(gen[gi], wdata_q, wstrb_q)),
				.period(period_compare_a_ch0),
				.mode(mode),
				.sel(bsel[gi]),
				.cm_ev(cm_ev),
				.udf_ev(udf_ev),
				.gen(gen[gi])
			);

			cpb_phase u_phase (
				.aclk(aclk),
				.aresetn(aresetn),
				.active(running && comp),
				.cnt0(counter_ch0),
				.cnt1(counter_ch1),
				.gen(gen[gi]),
				.period(period_compare_a_ch0),
				.ols_n(normal_phase_level_sel),
				.ols_c(counter_phase_level_sel),
				.out_n(pwm_normal[gi]),
				.out_c(pwm_counter[gi])
			);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bsel <= 3'b000;
		end else if (wr_fire && awaddr_q == `CPB_OFS_BSEL && wstrb_q[0]) begin
			bsel <= wdata_q[2:0];
		end
	end

	// Events only on the exact steps m->m+1 and 0->FFFFH
	assign cm_ev = comp && running && dir_up && counter_ch0 == period_compare_a_ch0;
	assign udf_ev = comp && running && !dir_up && counter_ch1 == `CPB_CNT_ZERO;
	// Overflow only exists outside complementary mode
	assign ovf_ev = !comp && running && counter_ch0 == `CPB_CNT_MAX;

	assign cnt0_merge = merge16(counter_ch0, wdata_q, wstrb_q);
	assign cnt1_merge = merge16(counter_ch1, wdata_q, wstrb_q);

	// Software load wins over counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_ch0 <= `CPB_CNT_ZERO;
		end else if (wr_fire && awaddr_q == `CPB_OFS_CNT0) begin
			counter_ch0 <= cnt0_merge;
		end else if (running) begin
			counter_ch0 <= (dir_up || !comp) ? counter_ch0 + `CPB_CNT_ONE :
				counter_ch0 - `CPB_CNT_ONE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_ch1 <= `CPB_CNT_ZERO;
		end else if (wr_fire && awaddr_q == `CPB_OFS_CNT1) begin
			counter_ch1 <= cnt1_merge;
		end else if (comp ? running : counter1_run_bit) begin
			counter_ch1 <= (dir_up || !comp) ? counter_ch1 + `CPB_CNT_ONE :
				counter_ch1 - `CPB_CNT_ONE;
		end
	end

	// Turn down after reaching m+1, turn up after reaching FFFFH
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_up <= 1'b1;
		end else if (!comp) begin
			dir_up <= 1'b1;
		end else if (cm_ev) begin
			dir_up <= 1'b0;
		end else if (udf_ev) begin
			dir_up <= 1'b1;
		end
	end

	// Writing 0 clears a flag; a same-cycle event keeps it set
	assign stat_clr = (wr_fire && awaddr_q == `CPB_OFS_STAT && wstrb_q[0]) ?
		~wdata_q[`CPB_STAT_W-1:0] : 3'b000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_match_a_flag <= 1'b0;
			underflow_flag <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			compare_match_a_flag <= cm_ev || (compare_match_a_flag && !stat_clr[0]);
			underflow_flag <= udf_ev || (underflow_flag && !stat_clr[1]);
			overflow_flag <= ovf_ev || (overflow_flag && !stat_clr[2]);
		end
	end

	// Read channel: one read at a time, answered the cycle after the address
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`CPB_OFS_CTRL: next_rdata = {26'h0, counter_phase_level_sel,
				normal_phase_level_sel, mode, counter1_run_bit, counter0_run_bit};
			`CPB_OFS_STAT: next_rdata = {29'h0, overflow_flag, underflow_flag,
				compare_match_a_flag};
			`CPB_OFS_PERIOD: next_rdata = {16'h0, period_compare_a_ch0};
			`CPB_OFS_GEN0: next_rdata = {16'h0, gen[0]};
			`CPB_OFS_GEN1: next_rdata = {16'h0, gen[1]};
			`CPB_OFS_GEN2: next_rdata = {16'h0, gen[2]};
			`CPB_OFS_BUF0: next_rdata = {16'h0, buf_q[0]};
			`CPB_OFS_BUF1: next_rdata = {16'h0, buf_q[1]};
			`CPB_OFS_BUF2: next_rdata = {16'h0, buf_q[2]};
			`CPB_OFS_BSEL: next_rdata = {29'h0, bsel};
			`CPB_OFS_CNT0: next_rdata = {16'h0, counter_ch0};
			`CPB_OFS_CNT1: next_rdata = {16'h0, counter_ch1};
			default: begin
				next_rdata = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CPB_RESP_OK;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_hit ? `CPB_RESP_OK : `CPB_RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // cpb_top

// [cpb_top_props.sv]
// Port-level checks of the complementary PWM timer
module cpb_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] pwm_normal,
	input wire logic [2:0] pwm_counter
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Level selects reset to 0, so the idle output level is 1
	a_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready
		&& s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
		&& pwm_normal == 3'h7 && pwm_counter == 3'h7) else $error("idle state wrong");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2c
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read bits set");
endmodule // cpb_top_props

// [cpb_top_test.sv]
// Self-checking bench of the complementary PWM timer
`include "cpb_defs.svh"
module cpb_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'h0;
	logic [2:0] pwm_normal;
	logic [2:0] pwm_counter;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] st;
	logic [1:0] rr;

	always #2 aclk = ~aclk;

	cpb_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_normal, .pwm_counter);

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			$display("mismatch at %0t: timeout", $time);
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshakes judged just before the edge, so no race with the slave
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ah;
		logic wh;
		logic bh;
		logic [1:0] r;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		bh = 1'h0;
		while (!bh) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'h0;
			if (wh) s_axi_wvalid <= 1'h0;
		end
		// Response ready stays up between calls, never toggled in one step
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah;
		logic h;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		h = 1'h0;
		while (!h) begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			h = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'h0;
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, {16'h0, e});
		chk({30'h0, r}, {30'h0, er});
	endtask

	// Select bits cleared around the write so no half-written value moves
	task automatic set_buf(input logic [7:0] a, input logic [15:0] v);
		wr(`CPB_OFS_BSEL, 16'h0, 2'h0);
		wr(a, v, 2'h0);
		wr(`CPB_OFS_BSEL, 16'h7, 2'h0);
	endtask

	// Bit 0 marks the period match, bit 1 the underflow
	task automatic sync(input int b);
		wr(`CPB_OFS_STAT, 16'h0, 2'h0);
		st = 32'h0;
		while (st[b] !== 1'h1)
			rd(`CPB_OFS_STAT, st, rr);
	endtask

	// New value must appear at event e only, not at the other event
	task automatic xfer(input logic [7:0] b, g, input logic [15:0] v, o, input int e);
		sync(e);
		set_buf(b, v);
		sync(1 - e);
		rchk(g, o, 2'h0);
		sync(e);
		rchk(g, v, 2'h0);
	endtask

	task automatic pwm_chk(input int ch, input logic [1:0] e);
		repeat (130) begin
			@(negedge aclk);
			chk({30'h0, pwm_normal[ch], pwm_counter[ch]}, {30'h0, e});
		end
		@(posedge aclk);
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rchk(`CPB_OFS_PERIOD, 16'hffff, 2'h0);
		rchk(`CPB_OFS_BUF1, 16'hffff, 2'h0);
		rchk(`CPB_OFS_STAT, 16'h0, 2'h0);
		rchk(8'h30, 16'h0, 2'h2);
		wr(8'h34, 16'h1, 2'h2);
		wr(`CPB_OFS_CTRL, 16'h0, 2'h0);
		wr(`CPB_OFS_CTRL, 16'h38, 2'h0);
		wr(`CPB_OFS_PERIOD, 16'h40, 2'h0);
		wr(`CPB_OFS_GEN0, 16'h10, 2'h0);
		wr(`CPB_OFS_CNT0, 16'h2, 2'h0);
		set_buf(`CPB_OFS_BUF1, 16'h0);
		set_buf(`CPB_OFS_BUF2, 16'h50);
		wr(`CPB_OFS_CTRL, 16'h3b, 2'h0);
		repeat (300) @(posedge aclk);
		rchk(`CPB_OFS_GEN0, 16'h10, 2'h0);
		rchk(`CPB_OFS_GEN1, 16'h0, 2'h0);
		rchk(`CPB_OFS_GEN2, 16'h50, 2'h0);
		pwm_chk(1, 2'h1);
		pwm_chk(2, 2'h2);
		wr(`CPB_OFS_PERIOD, 16'h20, 2'h0);
		wr(`CPB_OFS_GEN0, 16'h30, 2'h0);
		rchk(`CPB_OFS_PERIOD, 16'h40, 2'h0);
		rchk(`CPB_OFS_GEN0, 16'h10, 2'h0);
		// Just past the peak counter 0 is high: only the counter phase is active
		sync(0);
		@(negedge aclk);
		chk({30'h0, pwm_normal[0], pwm_counter[0]}, 32'h1);
		// Just past the trough counter 0 is low: only the normal phase is active
		sync(1);
		@(negedge aclk);
		chk({30'h0, pwm_normal[0], pwm_counter[0]}, 32'h2);
		@(posedge aclk);
		xfer(`CPB_OFS_BUF0, `CPB_OFS_GEN0, 16'h8, 16'h10, 1);
		xfer(`CPB_OFS_BUF2, `CPB_OFS_GEN2, 16'h18, 16'h50, 1);
		set_buf(`CPB_OFS_BUF1, 16'h50);
		sync(1);
		sync(0);
		sync(1);
		rchk(`CPB_OFS_GEN1, 16'h0, 2'h0);
		xfer(`CPB_OFS_BUF1, `CPB_OFS_GEN1, 16'h20, 16'h0, 0);
		xfer(`CPB_OFS_BUF1, `CPB_OFS_GEN1, 16'h0, 16'h20, 0);
		rd(`CPB_OFS_STAT, st, rr);
		chk({31'h0, st[2]}, 32'h0);
		wr(`CPB_OFS_CTRL, 16'h30, 2'h0);
		wr(`CPB_OFS_CTRL, 16'h30, 2'h0);
		wr(`CPB_OFS_CTRL, 16'h3c, 2'h0);
		wr(`CPB_OFS_CTRL, 16'h3f, 2'h0);
		xfer(`CPB_OFS_BUF0, `CPB_OFS_GEN0, 16'hc, 16'h8, 0);
		xfer(`CPB_OFS_BUF2, `CPB_OFS_GEN2, 16'h60, 16'h18, 1);
		wr(`CPB_OFS_CTRL, 16'h30, 2'h0);
		wr(`CPB_OFS_CTRL, 16'h30, 2'h0);
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		chk({26'h0, pwm_normal, pwm_counter}, 32'h0);
		complete_run();
	end
endmodule // cpb_top_test

bind cpb_top cpb_top_props chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_normal, .pwm_counter);

// [cpb_xfer.sv]
// Buffer to compare transfer unit for one duty channel
`include "cpb_defs.svh"
module cpb_xfer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] buf_val,
	input wire logic buf_wr,
	input wire logic gen_wr,
	input wire logic [15:0] gen_wdata,
	input wire logic [15:0] period,
	input wire logic [1:0] mode,
	input wire logic sel,
	input wire logic cm_ev,
	input wire logic udf_ev,
	output logic [15:0] gen
);
	cpb_pkg::cpb_fix_t fix;
	logic touched;
	logic full;
	logic zero;
	logic want_cm;
	logic want_udf;
	logic xfer;

	assign full = buf_val >= period;
	assign zero = buf_val == `CPB_CNT_ZERO;

	always_comb begin
		want_cm = 1'b0;
		want_udf = 1'b0;
		if (zero) begin
			want_cm = fix != cpb_pkg::cpb_fix_full;
		end else if (full) begin
			// Untouched reset value must not force 0%
			want_udf = touched && fix != cpb_pkg::cpb_fix_zero;
		end else begin
			unique case (fix)
				cpb_pkg::cpb_fix_none: begin
					want_cm = mode == `CPB_MODE_CMA;
					want_udf = mode == `CPB_MODE_UDF;
				end
				cpb_pkg::cpb_fix_full: want_udf = 1'b1;
				cpb_pkg::cpb_fix_zero: want_cm = 1'b1;
				default: want_udf = 1'b1;
			endcase
		end
	end

	// Only in buffer operation and complementary mode
	assign xfer = sel && mode[1] && ((want_cm && cm_ev) || (want_udf && udf_ev));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			touched <= 1'b0;
		end else if (buf_wr) begin
			touched <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen <= `CPB_REG_RST;
			fix <= cpb_pkg::cpb_fix_none;
		end else if (xfer) begin
			gen <= buf_val;
			fix <= zero ? cpb_pkg::cpb_fix_zero :
				(full ? cpb_pkg::cpb_fix_full : cpb_pkg::cpb_fix_none);
		end else if (gen_wr) begin
			gen <= gen_wdata;
		end
	end
endmodule // cpb_xfer
